/* design/tcs_pkg.sv */
// Summary of operation
// R1: Combination strap wins, else formatted strap.
// R2: Unit type restricted to mode's transports.
// R3: Streaming mode serves four independent drives.
// R4: Shift to streaming when buffer sustains.
// R5: Formatted mode uses formatter address zero.
// R6: Combination maps units 0,3 streaming, 1,2 formatted.
// R7: Formatter select high for start/stop units.
// R8: Density handled per unit in all modes.
// R9: Reset strap holds coupler in reset.
// R10: Respond only at enabled unit addresses.
// R11: Write data latched on chosen strobe edge.
// R12: Vector straps give bits 8..2, step 4.
// R13: Fixed strap forces unit 0 vector 224.
// R14: Range select: standard or jumpered alternate.
// R15: Unit bases step 4 from range start.
package tcs_pkg;
    typedef enum logic [1:0] {TCS_STREAMING, TCS_FORMATTED, TCS_COMBINATION} tcs_mode_t;
    localparam logic [17:0] TCS_RANGE_STD = 18'o772520;
    localparam logic [17:0] TCS_RANGE_ALT_G = 18'o772440;
    localparam logic [17:0] TCS_RANGE_ALT_H = 18'o776300;
    localparam logic [17:0] TCS_RANGE_ALT_J = 18'o777460;
    localparam logic [17:0] TCS_UNIT_STEP = 18'o4;
    localparam logic [8:0] TCS_FIXED_VECTOR = 9'o224;
    localparam logic [8:0] TCS_VECTOR_STEP = 9'o4;
    localparam logic [7:0] TCS_STREAM_THRESHOLD = 8'h40;
    localparam int TCS_UNITS = 4;
    // APB register byte offsets, then the control register reset value
    localparam logic [7:0] TCS_REG_STATUS = 8'h00;
    localparam logic [7:0] TCS_REG_CTRL = 8'h04;
    localparam logic [7:0] TCS_REG_VECT01 = 8'h08;
    localparam logic [7:0] TCS_REG_VECT23 = 8'h0c;
    localparam logic [7:0] TCS_REG_DENS = 8'h10;
    localparam logic [7:0] TCS_REG_WDATA = 8'h14;
    localparam logic [7:0] TCS_REG_ADDR = 8'h18;
    localparam logic [7:0] TCS_REG_FILL = 8'h1c;
    localparam logic [7:0] TCS_CTRL_RESET = 8'h00;
endpackage

/* design/tcs_strap_if.sv */
`timescale 1ns/1ns
// Synchronised strap set shared by top and decoder
interface tcs_strap_if;
    logic combination;
    logic formatted;
    logic fixed_vector;
    logic [6:0] vector_bits;
    logic standard_range;
    logic alternate_range;
    logic [2:0] range_jumper;
    logic [3:0] unit_enable;
    modport src (output combination, formatted, fixed_vector, vector_bits,
        standard_range, alternate_range, range_jumper, unit_enable);
    modport dst (input combination, formatted, fixed_vector, vector_bits,
        standard_range, alternate_range, range_jumper, unit_enable);
endinterface

/* design/tcs_sync3.sv */
`timescale 1ns/1ns
module tcs_sync3 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Async in, filtered out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;
    // Change accepted once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= (s2_q == s3_q) ? s3_q : out_q;
        end
    end
    assign sync_out = out_q;
endmodule

/* design/tcs_decode.sv */
`timescale 1ns/1ns
module tcs_decode
    import tcs_pkg::*;
(
    // Straps
    tcs_strap_if.dst st,
    // Decoded configuration
    output tcs_mode_t mode,
    output logic [17:0] range_base,
    output logic range_valid,
    output logic [8:0] vec0,
    output logic [8:0] vec1,
    output logic [8:0] vec2,
    output logic [8:0] vec3
);
    logic [8:0] vbase;
    // Mode select
    assign mode = st.combination ? TCS_COMBINATION :
                  (st.formatted ? TCS_FORMATTED : TCS_STREAMING); // R1
    // Range select; both straps on is invalid
    assign range_valid = st.standard_range ^ st.alternate_range; // R14
    assign range_base = st.standard_range ? TCS_RANGE_STD :
                        st.range_jumper[0] ? TCS_RANGE_ALT_G :
                        st.range_jumper[1] ? TCS_RANGE_ALT_H : TCS_RANGE_ALT_J; // R14
    // Vectors
    assign vbase = {st.vector_bits, 2'b00}; // R12
    assign vec0 = st.fixed_vector ? TCS_FIXED_VECTOR : vbase; // R13
    assign vec1 = 9'(vbase + TCS_VECTOR_STEP); // R12
    assign vec2 = 9'(vbase + 9'(2 * TCS_VECTOR_STEP)); // R12
    assign vec3 = 9'(vbase + 9'(3 * TCS_VECTOR_STEP)); // R12
endmodule

/* design/tcs_coupler.sv */
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
module tcs_coupler
    import tcs_pkg::*;
(
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Straps
    input wire logic coupler_reset_strap,
    input wire logic formatted_select_strap,
    input wire logic combination_select_strap,
    input wire logic [6:0] vector_strap,
    input wire logic unit0_fixed_vector_strap,
    input wire logic standard_range_strap,
    input wire logic alternate_range_strap,
    input wire logic [2:0] range_jumper,
    input wire logic [3:0] unit_enable_strap,
    input wire logic write_strobe_edge_strap,
    // Host bus address probe
    input wire logic [17:0] bus_addr,
    output logic bus_hit,
    output logic [1:0] bus_unit,
    // Transport side
    input wire logic write_strobe,
    input wire logic [7:0] transport_wdata,
    input wire logic [1:0] sel_unit,
    output logic formatter_address_select,
    output logic [1:0] transport_address,
    output logic streaming_cmd,
    output logic unit_allowed,
    output logic [1:0] unit_density,
    output logic [8:0] interrupt_vector_value,
    output logic coupler_held
);
    tcs_strap_if st();
    tcs_mode_t mode;
    logic [17:0] range_base;
    logic range_valid;
    logic [8:0] vec [TCS_UNITS];
    logic [2:0] sync_misc;
    logic [7:0] twd_sync;
    logic [1:0] su_sync;
    logic ws_s1_q, ws_s2_q, ws_s3_q, ws_prev_q;
    logic [7:0] wdata_q;
    logic [7:0] fill_q;
    logic [7:0] fill_wr;
    logic [7:0] density_q;
    logic [1:0] ctrl_q;
    logic [3:0] hit_vec;
    logic [1:0] hit_idx;
    logic strobe_rise, strobe_fall, latch_ev;
    logic unit_is_stream, unit_is_fmt;
    logic apb_wr, apb_rd, addr_ok;
    logic soft_reset;
    logic [31:0] rd_mux;
    logic [31:0] prdata_q;

    // Strap and transport input synchronisers
    tcs_sync3 #(.W(3)) u_sync_misc (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({coupler_reset_strap, write_strobe_edge_strap, unit0_fixed_vector_strap}),
        .sync_out(sync_misc)
    );
    tcs_sync3 #(.W(18)) u_sync_cfg (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({combination_select_strap, formatted_select_strap, vector_strap,
                   standard_range_strap, alternate_range_strap, range_jumper,
                   unit_enable_strap}),
        .sync_out({st.combination, st.formatted, st.vector_bits, st.standard_range,
                   st.alternate_range, st.range_jumper, st.unit_enable})
    );
    tcs_sync3 #(.W(10)) u_sync_tp (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({transport_wdata, sel_unit}),
        .sync_out({twd_sync, su_sync})
    );
    assign st.fixed_vector = sync_misc[0];

    tcs_decode u_dec (
        .st(st),
        .mode(mode),
        .range_base(range_base),
        .range_valid(range_valid),
        .vec0(vec[0]),
        .vec1(vec[1]),
        .vec2(vec[2]),
        .vec3(vec[3])
    );

    // Held in reset by strap or software
    assign soft_reset = sync_misc[2] | ctrl_q[0]; // R9
    assign coupler_held = soft_reset;

    // Per-unit address compare
    genvar gi;
    generate
        for (gi = 0; gi < TCS_UNITS; gi++) begin : g_unit
            assign hit_vec[gi] = range_valid && st.unit_enable[gi] && !soft_reset &&
                (bus_addr == 18'(range_base + 18'(gi) * TCS_UNIT_STEP)); // R10 R15
        end
    endgenerate
    assign hit_idx = hit_vec[3] ? 2'd3 : hit_vec[2] ? 2'd2 : hit_vec[1] ? 2'd1 : 2'd0;
    assign bus_hit = |hit_vec; // R10
    assign bus_unit = hit_idx;

    // Unit type by mode
    assign unit_is_stream = (mode == TCS_STREAMING) ||
        (mode == TCS_COMBINATION && (su_sync == 2'd0 || su_sync == 2'd3)); // R2 R3 R6
    assign unit_is_fmt = (mode == TCS_FORMATTED) ||
        (mode == TCS_COMBINATION && (su_sync == 2'd1 || su_sync == 2'd2)); // R2 R6
    assign unit_allowed = !soft_reset && (unit_is_stream || unit_is_fmt); // R2
    assign formatter_address_select = !soft_reset && mode == TCS_COMBINATION &&
        unit_is_fmt; // R5 R7
    assign transport_address = su_sync; // R6
    assign interrupt_vector_value = vec[su_sync]; // R12 R13
    assign unit_density = density_q[2*su_sync +: 2]; // R8

    // Write strobe edges
    assign strobe_rise = ws_s2_q && ws_s3_q && !ws_prev_q;
    assign strobe_fall = !ws_s2_q && !ws_s3_q && ws_prev_q;
    assign latch_ev = sync_misc[1] ? strobe_rise : strobe_fall; // R11

    // Strobe sampling, data latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ws_s1_q <= 1'b0;
            ws_s2_q <= 1'b0;
            ws_s3_q <= 1'b0;
            ws_prev_q <= 1'b0;
            wdata_q <= 8'h00;
        end else begin
            ws_s1_q <= write_strobe;
            ws_s2_q <= ws_s1_q;
            ws_s3_q <= ws_s2_q;
            if (ws_s2_q == ws_s3_q) begin
                ws_prev_q <= ws_s3_q;
            end
            if (soft_reset) begin
                wdata_q <= 8'h00; // R9
            end else if (latch_ev) begin
                wdata_q <= twd_sync; // R11
            end
        end
    end

    // Stream shift once buffer sustains rate
    assign streaming_cmd = !soft_reset && unit_is_stream &&
        (fill_q >= TCS_STREAM_THRESHOLD); // R4

    // APB decode
    assign apb_wr = psel && penable && pwrite;
    // Read captured in setup cycle, so prdata comes from a flop
    assign apb_rd = psel && !penable && !pwrite;
    assign addr_ok = paddr[1:0] == 2'b00 && paddr <= TCS_REG_FILL;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign fill_wr = pwdata[7:0];

    // Read mux
    assign rd_mux = (paddr == TCS_REG_STATUS) ? {24'h0, range_valid, soft_reset,
                        streaming_cmd, formatter_address_select, 2'(mode), hit_idx} :
                    (paddr == TCS_REG_CTRL) ? {30'h0, ctrl_q} :
                    (paddr == TCS_REG_VECT01) ? {7'h0, vec[1], 7'h0, vec[0]} :
                    (paddr == TCS_REG_VECT23) ? {7'h0, vec[3], 7'h0, vec[2]} :
                    (paddr == TCS_REG_DENS) ? {24'h0, density_q} :
                    (paddr == TCS_REG_WDATA) ? {24'h0, wdata_q} :
                    (paddr == TCS_REG_ADDR) ? {14'h0, range_base} :
                    (paddr == TCS_REG_FILL) ? {24'h0, fill_q} : 32'h0;

    // Register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 2'(TCS_CTRL_RESET);
            density_q <= 8'h00;
            fill_q <= 8'h00;
            prdata_q <= 32'h0;
        end else begin
            if (apb_rd) begin
                prdata_q <= addr_ok ? rd_mux : 32'h0;
            end
            if (sync_misc[2]) begin
                fill_q <= 8'h00; // R9
            end else if (apb_wr && paddr == TCS_REG_FILL) begin
                fill_q <= fill_wr;
            end
            if (apb_wr && paddr == TCS_REG_CTRL) begin
                ctrl_q <= pwdata[1:0];
            end
            if (apb_wr && paddr == TCS_REG_DENS) begin
                density_q <= pwdata[7:0]; // R8
            end
        end
    end
    assign prdata = prdata_q;

    // Checks
    property p_mode_comb;
        @(posedge pclk) disable iff (!presetn) st.combination |-> mode == TCS_COMBINATION;
    endproperty
    a_mode_comb: assert property (p_mode_comb) else $error("mode not combination"); // R1
    property p_fad;
        @(posedge pclk) disable iff (!presetn)
        (mode == TCS_COMBINATION && !soft_reset && su_sync inside {2'd1, 2'd2})
        |-> formatter_address_select;
    endproperty
    a_fad: assert property (p_fad) else $error("formatter select missing"); // R7
    property p_fad_low;
        @(posedge pclk) disable iff (!presetn)
        mode != TCS_COMBINATION |-> !formatter_address_select;
    endproperty
    a_fad_low: assert property (p_fad_low) else $error("formatter address nonzero"); // R5
    property p_hit_en;
        @(posedge pclk) disable iff (!presetn) bus_hit |-> st.unit_enable[bus_unit];
    endproperty
    a_hit_en: assert property (p_hit_en) else $error("hit on disabled unit"); // R10
    property p_fixed;
        @(posedge pclk) disable iff (!presetn) st.fixed_vector |-> vec[0] == TCS_FIXED_VECTOR;
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed vector wrong"); // R13
    property p_vstep;
        @(posedge pclk) disable iff (!presetn) vec[2] == 9'(vec[1] + 9'd4);
    endproperty
    a_vstep: assert property (p_vstep) else $error("vector step wrong"); // R12
    property p_held;
        @(posedge pclk) disable iff (!presetn) soft_reset |-> !bus_hit && !streaming_cmd;
    endproperty
    a_held: assert property (p_held) else $error("active while held"); // R9
    property p_latch;
        @(posedge pclk) disable iff (!presetn)
        (latch_ev && !soft_reset) |=> wdata_q == $past(twd_sync);
    endproperty
    a_latch: assert property (p_latch) else $error("write data not latched"); // R11
    property p_stream;
        @(posedge pclk) disable iff (!presetn)
        (fill_q < TCS_STREAM_THRESHOLD) |-> !streaming_cmd;
    endproperty
    a_stream: assert property (p_stream) else $error("early stream shift"); // R4
    // Mode from the formatted strap when combination is off
    property p_mode_fmt;
        @(posedge pclk) disable iff (!presetn)
        (!st.combination && st.formatted) |-> mode == TCS_FORMATTED;
    endproperty
    a_mode_fmt: assert property (p_mode_fmt) else $error("mode not formatted"); // R1
    property p_mode_stream;
        @(posedge pclk) disable iff (!presetn)
        (!st.combination && !st.formatted) |-> mode == TCS_STREAMING;
    endproperty
    a_mode_stream: assert property (p_mode_stream) else $error("mode not streaming"); // R1
    // Streaming units in combination mode keep select low
    property p_fad_stream;
        @(posedge pclk) disable iff (!presetn)
        (mode == TCS_COMBINATION && su_sync inside {2'd0, 2'd3})
        |-> !formatter_address_select;
    endproperty
    a_fad_stream: assert property (p_fad_stream) else $error("select on stream unit"); // R7
    // Every unit served while running
    property p_allowed;
        @(posedge pclk) disable iff (!presetn) !soft_reset |-> unit_allowed;
    endproperty
    a_allowed: assert property (p_allowed) else $error("unit refused"); // R2
    // Both range straps on gives no response
    property p_range_both;
        @(posedge pclk) disable iff (!presetn)
        (st.standard_range && st.alternate_range) |-> !bus_hit;
    endproperty
    a_range_both: assert property (p_range_both) else $error("hit with both ranges"); // R14
    // Unit 0 vector from straps when not fixed
    property p_vec0_free;
        @(posedge pclk) disable iff (!presetn)
        !st.fixed_vector |-> vec[0] == {st.vector_bits, 2'b00};
    endproperty
    a_vec0_free: assert property (p_vec0_free) else $error("unit 0 vector wrong"); // R12
    // Held coupler keeps data latch clear; fill cleared only while the reset strap holds
    property p_held_wdata;
        @(posedge pclk) disable iff (!presetn) soft_reset |=> wdata_q == 8'h00;
    endproperty
    a_held_wdata: assert property (p_held_wdata) else $error("data latch not cleared"); // R9
    property p_held_fill;
        @(posedge pclk) disable iff (!presetn) sync_misc[2] |=> fill_q == 8'h00;
    endproperty
    a_held_fill: assert property (p_held_fill) else $error("fill not cleared"); // R9
    // Shift to streaming once fill reaches threshold
    property p_stream_on;
        @(posedge pclk) disable iff (!presetn)
        (!soft_reset && unit_is_stream && fill_q >= TCS_STREAM_THRESHOLD) |-> streaming_cmd;
    endproperty
    a_stream_on: assert property (p_stream_on) else $error("stream shift missing"); // R4
    // Main scenarios
    c_fixed: cover property (@(posedge pclk) st.fixed_vector && bus_hit);
    c_lead: cover property (@(posedge pclk) sync_misc[1] && latch_ev);
    c_comb: cover property (@(posedge pclk) formatter_address_select);
    c_hit: cover property (@(posedge pclk) bus_hit);
    c_stream: cover property (@(posedge pclk) streaming_cmd);
endmodule

/* verification/tcs_transport_model.sv */
`timescale 1ns/1ns
// Transport side: formatter write strobe and data
module tcs_transport_model (
    // Clock
    input wire logic pclk,
    // Strobe and data toward the coupler
    output logic write_strobe,
    output logic [7:0] transport_wdata
);
    // Idle levels at time zero
    initial begin
        write_strobe = 1'b0;
        transport_wdata = 8'h00;
    end
    // One strobe pulse, data changes inside it
    task automatic send(input logic [7:0] a, input logic [7:0] b);
        @(posedge pclk);
        transport_wdata <= a;
        repeat (8) @(posedge pclk);
        write_strobe <= 1'b1;
        repeat (8) @(posedge pclk);
        transport_wdata <= b;
        repeat (8) @(posedge pclk);
        write_strobe <= 1'b0;
        repeat (8) @(posedge pclk);
        transport_wdata <= ~b; // Released, no longer valid
    endtask
endmodule

/* verification/tb.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module tb;
    import tcs_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic pready, pslverr, err, hit, fad, scmd, allowed, held;
    logic rst_s = 0, fmt_s = 0, comb_s = 0, fix_s = 0, std_s = 1, alt_s = 0, edge_s = 0;
    logic [6:0] vec_s = 0;
    logic [2:0] jmp = 0;
    logic [3:0] en_s = 4'hf;
    logic [17:0] bus_addr = 0, base;
    logic [1:0] sel_unit = 0, bunit, ta, dens;
    logic [8:0] ivv;
    logic [7:0] a, b;
    logic strobe;
    logic [7:0] tdata;
    tcs_mode_t em;
    int fail_count = 0, n_checks = 0;
    // Clock, 40 ns period
    always #20 pclk = ~pclk;
    tcs_transport_model tm_u (.pclk(pclk), .write_strobe(strobe), .transport_wdata(tdata));
    tcs_coupler dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .coupler_reset_strap(rst_s), .formatted_select_strap(fmt_s),
        .combination_select_strap(comb_s), .vector_strap(vec_s),
        .unit0_fixed_vector_strap(fix_s), .standard_range_strap(std_s),
        .alternate_range_strap(alt_s), .range_jumper(jmp), .unit_enable_strap(en_s),
        .write_strobe_edge_strap(edge_s), .bus_addr(bus_addr), .bus_hit(hit),
        .bus_unit(bunit), .write_strobe(strobe), .transport_wdata(tdata),
        .sel_unit(sel_unit), .formatter_address_select(fad), .transport_address(ta),
        .streaming_cmd(scmd), .unit_allowed(allowed), .unit_density(dens),
        .interrupt_vector_value(ivv), .coupler_held(held));
    // Verdict and end of run
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // One APB transfer, bounded wait for pready
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (n >= 50) begin
            fail_count++;
            print_verdict();
        end
    endtask
    // Strap sync latency plus margin
    task automatic settle;
        repeat (8) @(posedge pclk);
    endtask
    // Select a unit and let its synchroniser settle
    task automatic pick(input int u);
        @(posedge pclk);
        sel_unit <= 2'(u);
        repeat (6) @(posedge pclk);
    endtask
    function automatic logic [8:0] exp_vec(int u);
        if (u == 0 && fix_s)
            return 9'o224;
        return {vec_s, 2'b00} + 9'(4 * u);
    endfunction
    function automatic logic [17:0] exp_base(int k);
        case (k)
            1: return 18'o772440;
            2: return 18'o776300;
            3: return 18'o777460;
            default: return 18'o772520;
        endcase
    endfunction
    initial begin
        void'($urandom(19));
        repeat (6) @(posedge pclk);
        presetn <= 1;
        settle();
        // Mode decode and transport addressing per unit
        for (int m = 0; m < 4; m++) begin
            @(posedge pclk);
            {comb_s, fmt_s} <= 2'(m);
            settle();
            em = comb_s ? TCS_COMBINATION : (fmt_s ? TCS_FORMATTED : TCS_STREAMING);
            apb(0, 8'h00, 0);
            `CHK(r[3:2], 2'(em))
            for (int u = 0; u < 4; u++) begin
                pick(u);
                `CHK(fad, comb_s && (u == 1 || u == 2))
                `CHK(ta, 2'(u))
                `CHK(allowed, 1'b1)
            end
        end
        // Streaming shift at fill threshold
        @(posedge pclk);
        {comb_s, fmt_s} <= 2'b00;
        settle();
        apb(1, 8'h1c, 32'h3f);
        pick(0);
        `CHK(scmd, 1'b0)
        apb(1, 8'h1c, 32'h40);
        pick(3);
        `CHK(scmd, 1'b1)
        // Density per unit
        apb(1, 8'h10, $urandom);
        a = pwdata[7:0];
        for (int u = 0; u < 4; u++) begin
            pick(u);
            `CHK(dens, a[2*u+:2])
        end
        // Reset strap and soft reset
        rst_s <= 1;
        settle();
        `CHK(held, 1'b1)
        `CHK(allowed, 1'b0)
        rst_s <= 0;
        settle();
        `CHK(held, 1'b0)
        apb(1, 8'h04, 1);
        @(posedge pclk);
        `CHK(held, 1'b1)
        apb(1, 8'h04, 0);
        @(posedge pclk);
        `CHK(held, 1'b0)
        // Unmapped offset refused
        apb(0, 8'h20, 0);
        `CHK({err, r}, {1'b1, 32'h0})
        // Vectors from straps, fixed unit 0
        for (int i = 0; i < 6; i++) begin
            vec_s <= 7'($urandom);
            fix_s <= 1'(i);
            settle();
            for (int u = 0; u < 4; u++) begin
                pick(u);
                `CHK(ivv, exp_vec(u))
            end
        end
        // Address ranges and unit enables, last pass both straps on
        for (int i = 0; i < 9; i++) begin
            int k;
            k = (i < 4) ? i : int'($urandom % 4);
            std_s <= (k == 0) || (i == 8);
            alt_s <= (k != 0) || (i == 8);
            jmp <= (k == 1) ? 3'h1 : (k == 2) ? 3'h2 : 3'h4;
            en_s <= 4'($urandom);
            settle();
            base = exp_base(k);
            for (int u = 0; u < 5; u++) begin
                bus_addr <= base + 18'(4 * u);
                repeat (2) @(posedge pclk);
                `CHK(hit, u < 4 && en_s[u[1:0]] && i != 8)
                if (hit === 1'b1)
                    `CHK(bunit, 2'(u))
            end
        end
        // Write data latched on the strapped strobe edge
        for (int e = 0; e < 2; e++) begin
            edge_s <= 1'(e);
            settle();
            a = 8'($urandom);
            b = ~a;
            tm_u.send(a, b);
            apb(0, 8'h14, 0);
            `CHK(r[7:0], e ? a : b)
        end
        print_verdict();
    end
endmodule
